//--- verilog/pse_emulator.sv
// Behaviour
// - Frames open with '#', close with '*'; letters match case exactly.
// - Two ASCII decimal digits after '#' give the address 00..99.
// - Address 00 is always accepted, whatever address is stored.
// - Version reply: 'v', type tag, version, date, ';'; external first.
// - Date reply: 'p', mm/yy, ';'; external date preferred.
// - Voltage reply: 'b' then 16-bit code, high byte first.
// - Temperature reply: 't' then 16-bit code, high byte first.
// - Serial reply: 33 chars, 's', five digits, 'S', five '0' chars, 21 zero bytes.
// - Magnitude reply: 'T' then squared magnitude float, low byte first.
// - Axis reply: 'A' then x, y, z floats, each low byte first.
// - Frequency set in 10 kHz steps; reply 'k' plus MHz float.
// - Out-of-range frequency is replaced by nearest calibrated one.
// - Filter digit 0..7 selects cut-off; reply 'f' plus digit.
// - Only the cut-off is emulated, never a notch response.
// - Auto-off command changes nothing and answers a single 'e'.
// - Power-off '!' is dropped silently with no reply.
// - Store-entry command opens a one-second window, no reply.
// - Address set inside window stores and echoes 'l'dd; else "ERR".
// - Nominal 9600 8N1; other line settings must not block traffic.
// - Frequency correction off sets 10 kHz instead of disabling.
`timescale 1ns/10ps
module pse_emulator
   import pse_pkg::*;
#(
   parameter int BIT_CYCLES = BIT_CYC,
   parameter int WIN_CYCLES = WIN_CYC,
   parameter int CAL_MIN = CAL_MIN_STEPS,
   parameter int CAL_MAX = CAL_MAX_STEPS,
   // Arbitrary identification text, sent as type and version.
   parameter logic [87:0] VER_TAG = 88'h58_50_31_30_30_3a_31_2e_30_30_20
)
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic rxd,
   output logic txd,
   input wire pse_meas_t meas,
   output logic [STEP_W-1:0] freq_steps,
   output logic [2:0] filter_sel,
   output logic [6:0] probe_addr,
   output logic store_window
);

   // ------------------------------------------------------------------
   // Serial line
   // ------------------------------------------------------------------
   logic rx_valid, tx_ready;
   logic [7:0] rx_data, tx_byte;
   wire tx_start;

   pse_uart #(.BIT_CYCLES(BIT_CYCLES)) u_uart (
      .clk(clk),
      .resetn(resetn),
      .rxd(rxd),
      .txd(txd),
      .rx_valid(rx_valid),
      .rx_data(rx_data),
      .tx_valid(tx_start),
      .tx_data(tx_byte),
      .tx_ready(tx_ready)
   );

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   function automatic logic is_digit(input logic [7:0] c);
      return c >= CH_ZERO && c <= CH_NINE;
   endfunction : is_digit

   function automatic logic [31:0] swap32(input logic [31:0] w);
      return {w[7:0], w[15:8], w[23:16], w[31:24]};
   endfunction : swap32

   // Returns {ok, steps}; spaces are skipped, one digit at least.
   function automatic logic [32:0] parse_steps(
      input logic [8*BUF_DEPTH-1:0] b, input logic [3:0] n);
      logic ok, seen;
      logic [31:0] v;
      logic [7:0] c;
      ok = 1'b1;
      seen = 1'b0;
      v = 32'h0;
      for (int i = 1; i < BUF_DEPTH; i++)
      begin
         c = b[8*i +: 8];
         if (4'(i) < n)
         begin
            if (is_digit(c))
            begin
               v = v * 32'd10 + {24'h0, c - CH_ZERO};
               seen = 1'b1;
            end
            else if (c != CH_SPACE)
               ok = 1'b0;
         end
      end
      return {ok && seen, v};
   endfunction : parse_steps

   function automatic pse_kind_t decode_kind(
      input logic [8*BUF_DEPTH-1:0] b, input logic [3:0] n,
      input logic win);
      logic [7:0] c0, c1, c2, c3;
      logic [32:0] ps;
      c0 = b[7:0];
      c1 = b[15:8];
      c2 = b[23:16];
      c3 = b[31:24];
      ps = parse_steps(b, n);
      decode_kind = K_NONE;
      if (c0 == CH_QM && n == 4'h2)
         case (c1)
            CH_LO_V: decode_kind = K_VER;
            CH_LO_P: decode_kind = K_DATE;
            CH_LO_B: decode_kind = K_VOLT;
            CH_LO_T: decode_kind = K_TEMP;
            CH_LO_S: decode_kind = K_SER;
            CH_UP_T: decode_kind = K_MAG;
            CH_UP_A: decode_kind = K_AXIS;
            default: decode_kind = K_NONE;
         endcase
      else if (c0 == CH_LO_K && ps[32])
         decode_kind = K_FREQ;
      else if (c0 == CH_LO_F && n == 4'h2 && is_digit(c1) && c1 <= CH_SEVEN)
         decode_kind = K_FILT;
      else if (c0 == CH_LO_E)
         decode_kind = K_ACK;
      else if (c0 == CH_BANG && n == 4'h1)
         decode_kind = K_OFF;
      else if (c0 == CH_AT && c1 == CH_LO_C && n == 4'h2)
         decode_kind = K_WIN;
      else if (c0 == CH_AT && c1 == CH_LO_L && n == 4'h4 &&
               is_digit(c2) && is_digit(c3))
         decode_kind = win ? K_ADDR : K_ERR;
   endfunction : decode_kind

   function automatic logic [5:0] reply_len(input pse_kind_t k);
      case (k)
         K_VER: return 6'(VER_TAG_LEN + DATE_LEN + 2);
         K_DATE: return 6'(DATE_LEN + 2);
         K_VOLT, K_TEMP, K_ADDR, K_ERR: return 6'd3;
         K_SER: return 6'd33;
         K_MAG, K_FREQ: return 6'd5;
         K_AXIS: return 6'd13;
         K_FILT: return 6'd2;
         K_ACK: return 6'd1;
         default: return 6'd0;
      endcase
   endfunction : reply_len

   // ------------------------------------------------------------------
   // Frame parser
   // ------------------------------------------------------------------
   pse_state_t state;
   logic [6:0] addr_rx;
   logic [7:0] addr_hi;
   logic [8*BUF_DEPTH-1:0] body;
   logic [3:0] body_cnt;
   logic [27:0] win_cnt;
   pse_kind_t kind;
   logic [5:0] idx, len;
   logic [95:0] snap;

   wire in_body = state == ST_BODY;
   wire got_hash = rx_valid && rx_data == CH_HASH;
   wire frame_end = in_body && rx_valid && rx_data == CH_STAR;
   wire addr_ok = addr_rx == 7'h00 || addr_rx == probe_addr;
   wire pse_kind_t next_kind = decode_kind(body, body_cnt, store_window);
   wire take = frame_end && addr_ok && next_kind != K_NONE;
   wire [32:0] steps_raw = parse_steps(body, body_cnt);
   wire [31:0] steps_on = (steps_raw[31:0] == 32'h0) ?
      32'(CORR_OFF_STEPS) : steps_raw[31:0];
   wire [31:0] steps_clip = (steps_on < 32'(CAL_MIN)) ? 32'(CAL_MIN) :
      (steps_on > 32'(CAL_MAX)) ? 32'(CAL_MAX) : steps_on;
   wire [39:0] date_sel = meas.ext_date_valid ?
      meas.ext_date : meas.int_date;
   wire [6:0] new_addr = 7'((body[23:16] - CH_ZERO) * 8'd10 +
      (body[31:24] - CH_ZERO));
   wire [5:0] jdx = idx - 6'd1;
   wire [7:0] snap_byte = snap[8'd95 - 8'(jdx) * 8'd8 -: 8];
   wire [7:0] tag_byte = VER_TAG[8'd87 - 8'(jdx) * 8'd8 -: 8];
   wire tx_acc = tx_start && tx_ready;
   assign tx_start = state == ST_SEND;
   assign store_window = win_cnt != 28'h0;

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state <= ST_IDLE;
         addr_rx <= 7'h00;
         addr_hi <= 8'h00;
         body <= '0;
         body_cnt <= 4'h0;
      end
      else if (state == ST_SEND)
      begin
         if (tx_acc && idx == len - 6'd1)
            state <= ST_IDLE;
      end
      else if (got_hash)
         state <= ST_ADDR_HI;
      else if (rx_valid)
         unique case (state)
            ST_IDLE: state <= ST_IDLE;
            ST_ADDR_HI:
               if (is_digit(rx_data))
               begin
                  addr_hi <= rx_data - CH_ZERO;
                  state <= ST_ADDR_LO;
               end
               else
                  state <= ST_IDLE;
            ST_ADDR_LO:
               if (is_digit(rx_data))
               begin
                  addr_rx <= 7'(addr_hi * 8'd10 + (rx_data - CH_ZERO));
                  body_cnt <= 4'h0;
                  state <= ST_BODY;
               end
               else
                  state <= ST_IDLE;
            ST_BODY:
               if (frame_end)
                  state <= (take && reply_len(next_kind) != 6'd0) ?
                     ST_SEND : ST_IDLE;
               else if (body_cnt == 4'(BUF_DEPTH))
                  state <= ST_IDLE;
               else
               begin
                  body[8*body_cnt +: 8] <= rx_data;
                  body_cnt <= body_cnt + 4'h1;
               end
            ST_SEND: state <= ST_SEND;
         endcase
   end

   // ------------------------------------------------------------------
   // Settings and address window
   // ------------------------------------------------------------------
   // The filter output is only a cut-off index; no notch shaping exists.
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         freq_steps <= FREQ_RESET;
         filter_sel <= FILT_RESET;
         probe_addr <= ADDR_RESET;
         win_cnt <= 28'h0;
      end
      else
      begin
         if (take && next_kind == K_FREQ)
            freq_steps <= steps_clip[STEP_W-1:0];
         if (take && next_kind == K_FILT)
            filter_sel <= body[10:8];
         if (take && next_kind == K_ADDR)
            probe_addr <= new_addr;
         if (take && next_kind == K_WIN)
            win_cnt <= 28'(WIN_CYCLES);
         else if (take && next_kind == K_ADDR)
            win_cnt <= 28'h0;
         else if (store_window)
            win_cnt <= win_cnt - 28'h1;
      end
   end

   // ------------------------------------------------------------------
   // Reply
   // ------------------------------------------------------------------
   // The frequency float is sampled as the first reply byte is accepted,
   // one clock after the new step count is stored, which is all the settling time it gets.
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         kind <= K_NONE;
         idx <= 6'd0;
         len <= 6'd0;
         snap <= '0;
      end
      else if (take)
      begin
         kind <= next_kind;
         idx <= 6'd0;
         len <= reply_len(next_kind);
         case (next_kind)
            K_VER, K_DATE: snap <= {date_sel, 56'h0};
            K_VOLT: snap <= {meas.volt_code, 80'h0};
            K_TEMP: snap <= {meas.temp_code, 80'h0};
            K_SER: snap <= {meas.serial, 56'h0};
            K_MAG: snap <= {swap32(meas.mag_sq), 64'h0};
            K_AXIS: snap <= {swap32(meas.field_x), swap32(meas.field_y),
               swap32(meas.field_z)};
            K_FILT: snap <= {body[15:8], 88'h0};
            K_ADDR: snap <= {body[23:16], body[31:24], 80'h0};
            default: snap <= '0;
         endcase
      end
      else if (tx_acc)
      begin
         idx <= idx + 6'd1;
         if (kind == K_FREQ && idx == 6'd0)
            snap <= {swap32(meas.freq_mhz), 64'h0};
      end
   end

   always_comb
   begin
      tx_byte = snap_byte;
      if (idx == 6'd0)
         case (kind)
            K_VER: tx_byte = CH_LO_V;
            K_DATE: tx_byte = CH_LO_P;
            K_VOLT: tx_byte = CH_LO_B;
            K_TEMP: tx_byte = CH_LO_T;
            K_SER: tx_byte = CH_LO_S;
            K_MAG: tx_byte = CH_UP_T;
            K_AXIS: tx_byte = CH_UP_A;
            K_FREQ: tx_byte = CH_LO_K;
            K_FILT: tx_byte = CH_LO_F;
            K_ACK: tx_byte = CH_LO_E;
            K_ADDR: tx_byte = CH_LO_L;
            K_ERR: tx_byte = CH_UP_E;
            default: tx_byte = 8'h00;
         endcase
      else if (kind == K_ERR)
         tx_byte = CH_UP_R;
      else if (kind == K_VER)
         tx_byte = (jdx < 6'(VER_TAG_LEN)) ? tag_byte :
            (jdx < 6'(VER_TAG_LEN + DATE_LEN)) ?
            snap[8'd95 - 8'(jdx - 6'(VER_TAG_LEN)) * 8'd8 -: 8] : CH_SEMI;
      else if (kind == K_DATE && jdx == 6'(DATE_LEN))
         tx_byte = CH_SEMI;
      else if (kind == K_SER && jdx >= 6'(SER_DIGITS))
         tx_byte = (jdx == 6'(SER_DIGITS)) ? CH_UP_S :
            (jdx < 6'(SER_ZERO_END)) ? CH_ZERO : 8'h00;
   end

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   frame_open_a: assert property (
      $rose(state == ST_ADDR_HI) |-> $past(got_hash))
      else $error("frame opened without hash");
   zero_addr_a: assert property (
      frame_end && addr_rx == 7'h00 && next_kind == K_ACK
      |=> state == ST_SEND && kind == K_ACK && tx_byte == CH_LO_E)
      else $error("address zero frame not answered");
   power_off_a: assert property (
      frame_end && next_kind == K_OFF |=> state == ST_IDLE [*2])
      else $error("power off produced a reply");
   foreign_addr_a: assert property (
      frame_end && !addr_ok |=> state == ST_IDLE && $stable(filter_sel)
      && $stable(freq_steps)) else $error("foreign frame acted on");
   addr_store_a: assert property (
      take && next_kind == K_ADDR
      |=> !store_window && probe_addr == $past(new_addr))
      else $error("address store did not close window");
   addr_err_a: assert property (
      take && next_kind == K_ERR |=> $stable(probe_addr) && kind == K_ERR
      && tx_byte == CH_UP_E ##1 tx_byte == CH_UP_R)
      else $error("ERR reply wrong");
   freq_range_a: assert property (
      freq_steps >= 20'(CAL_MIN) && freq_steps <= 20'(CAL_MAX))
      else $error("frequency outside calibrated range");
   filt_echo_a: assert property (
      state == ST_SEND && kind == K_FILT && idx == 6'd1
      |-> tx_byte == (CH_ZERO | {5'h00, filter_sel}))
      else $error("filter echo mismatch");
   volt_order_a: assert property (
      take && next_kind == K_VOLT
      |=> snap[95:80] == $past(meas.volt_code) && tx_byte == CH_LO_B)
      else $error("voltage high byte not first");

endmodule : pse_emulator

//--- verilog/pse_pkg.sv
package pse_pkg;

   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam int CLK_HZ = 200_000_000;
   localparam int BAUD = 9600;
   localparam int BIT_CYC = CLK_HZ / BAUD;
   localparam int WIN_MS = 1000;
   localparam int WIN_CYC = (CLK_HZ / 1000) * WIN_MS;

   // ------------------------------------------------------------------
   // Frame layout and reset values
   // ------------------------------------------------------------------
   localparam int BUF_DEPTH = 10;
   localparam int STEP_W = 20;
   localparam int CAL_MIN_STEPS = 1;
   localparam int CAL_MAX_STEPS = 820000;
   localparam int CORR_OFF_STEPS = 1;
   localparam logic [19:0] FREQ_RESET = 20'h02710;
   localparam logic [2:0] FILT_RESET = 3'h0;
   localparam logic [6:0] ADDR_RESET = 7'h00;
   localparam int VER_TAG_LEN = 11;
   localparam int DATE_LEN = 5;
   localparam int SER_DIGITS = 5;
   localparam int SER_ZERO_END = 11;

   // ------------------------------------------------------------------
   // Characters
   // ------------------------------------------------------------------
   localparam logic [7:0] CH_HASH = 8'h23;
   localparam logic [7:0] CH_STAR = 8'h2a;
   localparam logic [7:0] CH_QM = 8'h3f;
   localparam logic [7:0] CH_SEMI = 8'h3b;
   localparam logic [7:0] CH_ZERO = 8'h30;
   localparam logic [7:0] CH_SEVEN = 8'h37;
   localparam logic [7:0] CH_NINE = 8'h39;
   localparam logic [7:0] CH_SPACE = 8'h20;
   localparam logic [7:0] CH_AT = 8'h40;
   localparam logic [7:0] CH_BANG = 8'h21;
   localparam logic [7:0] CH_LO_V = 8'h76;
   localparam logic [7:0] CH_LO_P = 8'h70;
   localparam logic [7:0] CH_LO_B = 8'h62;
   localparam logic [7:0] CH_LO_T = 8'h74;
   localparam logic [7:0] CH_LO_S = 8'h73;
   localparam logic [7:0] CH_UP_S = 8'h53;
   localparam logic [7:0] CH_UP_T = 8'h54;
   localparam logic [7:0] CH_UP_A = 8'h41;
   localparam logic [7:0] CH_LO_K = 8'h6b;
   localparam logic [7:0] CH_LO_F = 8'h66;
   localparam logic [7:0] CH_LO_E = 8'h65;
   localparam logic [7:0] CH_LO_C = 8'h63;
   localparam logic [7:0] CH_LO_L = 8'h6c;
   localparam logic [7:0] CH_UP_E = 8'h45;
   localparam logic [7:0] CH_UP_R = 8'h52;

   // ------------------------------------------------------------------
   // Types
   // ------------------------------------------------------------------
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_ADDR_HI = 5'h02,
      ST_ADDR_LO = 5'h04,
      ST_BODY = 5'h08,
      ST_SEND = 5'h10
   } pse_state_t;

   typedef enum logic [3:0] {
      K_NONE, K_VER, K_DATE, K_VOLT, K_TEMP, K_SER, K_MAG, K_AXIS,
      K_FREQ, K_FILT, K_ACK, K_OFF, K_WIN, K_ADDR, K_ERR
   } pse_kind_t;

   // Text fields hold their first character in the top byte.
   typedef struct packed {
      logic ext_date_valid;
      logic [39:0] ext_date;
      logic [39:0] int_date;
      logic [15:0] volt_code;
      logic [15:0] temp_code;
      logic [39:0] serial;
      logic [31:0] mag_sq;
      logic [31:0] field_x;
      logic [31:0] field_y;
      logic [31:0] field_z;
      logic [31:0] freq_mhz;
   } pse_meas_t;

endpackage : pse_pkg

//--- verilog/pse_uart.sv
`timescale 1ns/10ps
module pse_uart
   import pse_pkg::*;
#(
   parameter int BIT_CYCLES = BIT_CYC
)
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic rxd,
   output logic txd,
   output logic rx_valid,
   output logic [7:0] rx_data,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   output logic tx_ready
);

   // ------------------------------------------------------------------
   // Receiver
   // ------------------------------------------------------------------
   // Parity and stop bit are not checked, so a host with other line
   // settings still gets its characters through.
   logic rx_s1, rx_s2, rx_busy;
   logic [15:0] rx_cnt;
   logic [3:0] rx_bit;
   logic [7:0] rx_shift;
   wire rx_tick = rx_busy && (rx_cnt == 16'h0000);

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rx_s1 <= 1'b1;
         rx_s2 <= 1'b1;
      end
      else
      begin
         rx_s1 <= rxd;
         rx_s2 <= rx_s1;
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rx_busy <= 1'b0;
         rx_cnt <= 16'h0000;
         rx_bit <= 4'h0;
         rx_shift <= 8'h00;
         rx_valid <= 1'b0;
         rx_data <= 8'h00;
      end
      else
      begin
         rx_valid <= 1'b0;
         if (!rx_busy)
         begin
            if (!rx_s2)
            begin
               rx_busy <= 1'b1;
               rx_cnt <= 16'(BIT_CYCLES / 2);
               rx_bit <= 4'h0;
            end
         end
         else if (!rx_tick)
            rx_cnt <= rx_cnt - 16'h0001;
         else
         begin
            rx_cnt <= 16'(BIT_CYCLES - 1);
            rx_bit <= rx_bit + 4'h1;
            if (rx_bit == 4'h0 && rx_s2)
               rx_busy <= 1'b0;
            else if (rx_bit == 4'h9)
            begin
               rx_busy <= 1'b0;
               rx_valid <= 1'b1;
               rx_data <= rx_shift;
            end
            else if (rx_bit != 4'h0)
               rx_shift <= {rx_s2, rx_shift[7:1]};
         end
      end
   end

   // ------------------------------------------------------------------
   // Transmitter
   // ------------------------------------------------------------------
   logic [9:0] tx_shift;
   logic [3:0] tx_left;
   logic [15:0] tx_cnt;
   assign tx_ready = (tx_left == 4'h0);

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         tx_shift <= 10'h3ff;
         tx_left <= 4'h0;
         tx_cnt <= 16'h0000;
      end
      else if (tx_ready)
      begin
         if (tx_valid)
         begin
            tx_shift <= {1'b1, tx_data, 1'b0};
            tx_left <= 4'ha;
            tx_cnt <= 16'(BIT_CYCLES - 1);
         end
      end
      else if (tx_cnt != 16'h0000)
         tx_cnt <= tx_cnt - 16'h0001;
      else
      begin
         tx_shift <= {1'b1, tx_shift[9:1]};
         tx_left <= tx_left - 4'h1;
         tx_cnt <= 16'(BIT_CYCLES - 1);
      end
   end

   assign txd = tx_shift[0];

endmodule : pse_uart

//--- verification/pse_host.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// Host side of the serial link, 8N1, low bit first.
// ------------------------------------------------------------
module pse_host
#(
   parameter int BIT_CYCLES = 16
)
(
   input wire logic clk,
   input wire logic txd,
   output logic rxd
);
   initial rxd = 1'b1;
   // The last stop bit is cut short so that a prompt reply is not missed.
   task send_byte(input logic [7:0] b, input int stop);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++)
      begin
         rxd <= f[i];
         repeat (i == 9 ? stop : BIT_CYCLES) @(posedge clk);
      end
   endtask : send_byte
   // Returns in mid stop bit; ok stays low when no start bit came in lim.
   task recv_byte(input int lim, output logic [7:0] b, output logic ok);
      int n;
      n = 0;
      b = 8'h00;
      while (txd !== 1'b0 && n < lim)
      begin
         @(posedge clk);
         n++;
      end
      ok = (n < lim);
      if (ok)
      begin
         repeat (BIT_CYCLES / 2) @(posedge clk);
         for (int i = 0; i < 8; i++)
         begin
            repeat (BIT_CYCLES) @(posedge clk);
            b[i] = txd;
         end
         repeat (BIT_CYCLES) @(posedge clk);
      end
   endtask : recv_byte
endmodule : pse_host

//--- verification/pse_emulator_test.sv
`timescale 1ns/10ps
module pse_emulator_test import pse_pkg::*;;
   localparam int BC = 16;
   localparam int WC = 2000;
   // Arbitrary identification text.
   localparam logic [87:0] TAG = 88'h41_42_43_3a_30_2e_31_32_33_34_20;
   logic clk, resetn, txd, rxd, store_window;
   logic [STEP_W-1:0] freq_steps;
   logic [2:0] filter_sel;
   logic [6:0] probe_addr;
   pse_meas_t meas;
   int error_cnt, num_checks, cyc;
   logic [7:0] q[$];
   pse_emulator #(.BIT_CYCLES(BC), .WIN_CYCLES(WC), .VER_TAG(TAG)) u_dut (
      .clk(clk), .resetn(resetn), .rxd(rxd), .txd(txd), .meas(meas),
      .freq_steps(freq_steps), .filter_sel(filter_sel),
      .probe_addr(probe_addr), .store_window(store_window));
   pse_host #(.BIT_CYCLES(BC)) u_host (.clk(clk), .txd(txd), .rxd(rxd));
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task put(input logic [87:0] v, input int n, input bit le);
      for (int i = 0; i < n; i++)
         q.push_back(le ? v[8*i+:8] : v[8*(n-1-i)+:8]);
   endtask : put
   // Sends a frame and compares the reply with q; empty q means silence.
   task txn(input string s);
      logic [7:0] b;
      logic ok;
      repeat (BC) @(posedge clk);
      for (int i = 0; i < s.len(); i++)
         u_host.send_byte(s[i], i == s.len() - 1 ? BC / 2 : BC);
      foreach (q[i])
      begin
         u_host.recv_byte(400, b, ok);
         chk(32'({ok, b}), 32'({1'b1, q[i]}));
      end
      if (q.size() == 0)
      begin
         u_host.recv_byte(400, b, ok);
         chk(32'(ok), 32'h0);
      end
      q = {};
   endtask : txn
   task t_codes;
      q.push_back("b"); put(meas.volt_code, 2, 0); txn("#00?b*");
      q.push_back("t"); put(meas.temp_code, 2, 0); txn("#00?t*");
      q.push_back("T"); put(meas.mag_sq, 4, 1); txn("#00?T*");
      q.push_back("A"); put(meas.field_x, 4, 1); put(meas.field_y, 4, 1);
      put(meas.field_z, 4, 1); txn("#00?A*");
      txn("#00?B*");
      $display("t_codes done");
   endtask : t_codes
   task t_text;
      q.push_back("p"); put(meas.int_date, 5, 0); q.push_back(";");
      txn("#00?p*");
      meas.ext_date_valid <= 1'b1;
      q.push_back("p"); put(meas.ext_date, 5, 0); q.push_back(";");
      txn("#00?p*");
      q.push_back("v"); put(TAG, 11, 0); put(meas.ext_date, 5, 0);
      q.push_back(";"); txn("#00?v*");
      q.push_back("s"); put(meas.serial, 5, 0); put("S00000", 6, 0);
      repeat (21) q.push_back(8'h00);
      txn("#00?s*");
      $display("t_text done");
   endtask : t_text
   task t_set;
      for (int n = 0; n < 8; n++)
      begin
         q.push_back("f"); q.push_back(8'h30 + 8'(n));
         txn($sformatf("#00f%0d*", n));
         chk(32'(filter_sel), n);
      end
      q.push_back("k"); put(meas.freq_mhz, 4, 1); txn("#00k 10000*");
      chk(32'(freq_steps), 10000);
      q.push_back("k"); put(meas.freq_mhz, 4, 1); txn("#00k0*");
      chk(32'(freq_steps), 1);
      q.push_back("k"); put(meas.freq_mhz, 4, 1); txn("#00k 999999*");
      chk(32'(freq_steps), 820000);
      q.push_back("e"); txn("#00e 300*");
      txn("#00!*");
      chk(32'({freq_steps, filter_sel}), 32'({20'(820000), 3'h7}));
      $display("t_set done");
   endtask : t_set
   task t_addr;
      put("ERR", 3, 0); txn("#00@l11*");
      chk(32'(probe_addr), 0);
      txn("#00@c*");
      chk(32'(store_window), 1);
      put("l12", 3, 0); txn("#00@l12*");
      chk(32'({probe_addr, store_window}), 32'({7'd12, 1'b0}));
      q.push_back("b"); put(meas.volt_code, 2, 0); txn("#12?b*");
      txn("#11?b*");
      q.push_back("b"); put(meas.volt_code, 2, 0); txn("#00?b*");
      txn("#00@c*");
      repeat (WC) @(posedge clk);
      chk(32'(store_window), 0);
      $display("t_addr done");
   endtask : t_addr
   task end_of_test;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : end_of_test
   // A hang is cut short well above the expected run of some 56000 cycles.
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 99000)
      begin
         error_cnt++;
         $display("Error at %0t: run timed out", $time);
         end_of_test;
      end
   end
   initial
   begin
      error_cnt = 0;
      num_checks = 0;
      cyc = 0;
      resetn = 1'b0;
      meas = '{1'b0, "03/21", "11/16", 16'h1234, 16'h0abc, "00042",
         32'h4148f5c3, 32'h3f800000, 32'hc0200000, 32'h40490fdb,
         32'h42c80000};
      repeat (20) @(posedge clk);
      chk({freq_steps, filter_sel, probe_addr, store_window, txd},
         {20'h02710, 3'h0, 7'h00, 1'b0, 1'b1});
      resetn <= 1'b1;
      repeat (3) @(posedge clk);
      t_codes;
      t_text;
      t_set;
      t_addr;
      end_of_test;
   end
endmodule : pse_emulator_test
